/* verilog/lnbt_pkg.sv */
// package: constants and carrier types for the lnb fault timer and tone control block
package lnbt_pkg;

	// system timebase
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned TONE_HZ          = 22_000;
	localparam int unsigned BOOST_TONE_RATIO = 16;
	localparam int unsigned BOOST_HZ         = TONE_HZ * BOOST_TONE_RATIO;
	localparam int unsigned BOOST_HALF_CYC   = CLK_HZ / (2 * BOOST_HZ);

	// overcurrent disable time, in ms and in clock cycles
	localparam int unsigned OC_DISABLE_MS    = 45;
	localparam int unsigned OC_DISABLE_CYC   = (CLK_HZ / 1000) * OC_DISABLE_MS;

	// detector accept bands in Hz, transmit (narrow) and receive (wide)
	localparam int unsigned XMT_LO_HZ        = 20_000;
	localparam int unsigned XMT_HI_HZ        = 24_000;
	localparam int unsigned RCV_LO_HZ        = 17_000;
	localparam int unsigned RCV_HI_HZ        = 27_000;

	// accept bands as period counts in clock cycles
	localparam logic [9:0] XMT_PER_MAX = 10'(CLK_HZ / XMT_LO_HZ);
	localparam logic [9:0] XMT_PER_MIN = 10'((CLK_HZ + XMT_HI_HZ - 1) / XMT_HI_HZ);
	localparam logic [9:0] RCV_PER_MAX = 10'(CLK_HZ / RCV_LO_HZ);
	localparam logic [9:0] RCV_PER_MIN = 10'((CLK_HZ + RCV_HI_HZ - 1) / RCV_HI_HZ);

	// reset values
	localparam logic RST_FAULT = 1'b0;
	localparam logic RST_SKIP  = 1'b0;

	// analog comparator results, all synchronous to clk
	typedef struct packed {
		logic oc_over_limit;  // output current above the set limit
		logic boost_above_hi; // boost would exceed the upper skip threshold
		logic boost_below_lo; // boost has fallen to the lower skip threshold
		logic backdrive;      // output forced above programmed level
		logic tone_sense;     // sliced sense input
		logic amp_xmt_ok;     // amplitude within transmit window
		logic amp_rcv_ok;     // amplitude within receive window
	} lnbt_sense_t;

	// detector operating mode
	typedef enum logic [0:0] {
		MODE_RCV = 1'b0,
		MODE_XMT = 1'b1
	} lnbt_mode_t;

endpackage : lnbt_pkg

/* verilog/lnbt_timebase.sv */
// timebase: one divider giving the boost switching clock and the tone phase
`timescale 1ns/10ps
module lnbt_timebase (
	input  wire logic clk,        // system clock
	input  wire logic rst_n,      // async reset, active low
	output logic      boost_ph,   // boost switching phase
	output logic      tone_ph     // tone phase, boost divided by sixteen
);
	logic [7:0] div_ff;
	logic [7:0] nxt_div;
	logic       boost_ff;
	logic       nxt_boost;
	logic [3:0] tone_cnt_ff;
	logic [3:0] nxt_tone_cnt;

	// divide clk to the boost rate, then by sixteen for the tone
	always_comb begin
		nxt_div      = div_ff + 8'h01;
		nxt_boost    = boost_ff;
		nxt_tone_cnt = tone_cnt_ff;
		if (div_ff == 8'(lnbt_pkg::BOOST_HALF_CYC - 1)) begin
			nxt_div   = 8'h00;
			nxt_boost = ~boost_ff;
			if (boost_ff) begin // one full boost period done
				nxt_tone_cnt = tone_cnt_ff + 4'h1;
			end
		end
	end

	// divider state, free running so boost and tone never drift apart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff      <= 8'h00;
			boost_ff    <= 1'b0;
			tone_cnt_ff <= 4'h0;
		end else begin
			div_ff      <= nxt_div;
			boost_ff    <= nxt_boost;
			tone_cnt_ff <= nxt_tone_cnt;
		end
	end

	// phases taken straight from flops
	assign boost_ph = boost_ff;
	assign tone_ph  = tone_cnt_ff[3];
endmodule : lnbt_timebase

/* verilog/lnbt_ctrl.sv */
// lnbt_ctrl: overcurrent disable timer, boost gating, tone gating and tone detector
`timescale 1ns/10ps
module lnbt_ctrl #(
	parameter int unsigned OC_CYC = lnbt_pkg::OC_DISABLE_CYC, // disable window in cycles
	parameter int unsigned OC_W   = 20                        // window counter width
) (
	input  wire logic                 clk,                        // 10 MHz system clock
	input  wire logic                 rst_n,                      // async reset, active low
	input  wire logic                 output_enable,              // host wants the output on
	input  wire logic                 reenable_pulse,             // host clears a latched fault
	input  wire logic                 tone_enable_input,          // host tone gate
	input  wire lnbt_pkg::lnbt_sense_t sense,                     // analog comparator results
	output logic                      lnb_output_on,              // output stage enabled
	output logic                      overcurrent_fault_flag,     // latched overcurrent fault
	output logic                      boost_gate,                 // boost switch drive
	output logic                      tone_out,                   // gated tone to output stage
	output logic                      pulldown_strong,            // 100 mA pull-down select
	output logic                      detect_mode_xmt,            // detector in transmit mode
	output logic                      tone_detected_flag,         // status flag, tone present
	output logic                      tdo_out,                    // detect pin output value
	output logic                      tdo_oe                      // detect pin output enable
);
	// timebase
	logic boost_ph;
	logic tone_ph;

	lnbt_timebase u_tb (
		.clk      (clk),
		.rst_n    (rst_n),
		.boost_ph (boost_ph),
		.tone_ph  (tone_ph)
	);

	// overcurrent window and fault latch
	logic [OC_W-1:0] oc_cnt_ff;
	logic [OC_W-1:0] nxt_oc_cnt;
	logic            fault_ff;
	logic            nxt_fault;
	logic            oc_expire;

	// count overload edges; any break, a latched fault or a disabled output restarts it
	always_comb begin
		oc_expire  = 1'b0;
		nxt_oc_cnt = oc_cnt_ff;
		nxt_fault  = fault_ff;
		if (!sense.oc_over_limit || fault_ff || !output_enable) begin
			nxt_oc_cnt = '0;
		end else if (oc_cnt_ff == OC_W'(OC_CYC - 1)) begin
			oc_expire  = 1'b1;
			nxt_oc_cnt = '0;
		end else begin
			nxt_oc_cnt = oc_cnt_ff + OC_W'(1); // surge tolerated while counting
		end
		if (reenable_pulse) begin
			nxt_fault = 1'b0;
		end
		if (oc_expire) begin
			nxt_fault = 1'b1; // set wins over a same-cycle clear
		end
	end

	// window counter and fault latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_cnt_ff <= '0;
			fault_ff  <= lnbt_pkg::RST_FAULT;
		end else begin
			oc_cnt_ff <= nxt_oc_cnt;
			fault_ff  <= nxt_fault;
		end
	end

	// boost pulse skipping with hysteresis
	logic skip_ff;
	logic nxt_skip;

	always_comb begin
		nxt_skip = skip_ff;
		if (sense.boost_above_hi) begin
			nxt_skip = 1'b1;
		end else if (sense.boost_below_lo) begin
			nxt_skip = 1'b0;
		end
	end

	// skip state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_ff <= lnbt_pkg::RST_SKIP;
		end else begin
			skip_ff <= nxt_skip;
		end
	end

	// tone detector: period of the sliced sense input checked against the band
	logic       sense_d_ff;
	logic [9:0] per_cnt_ff;
	logic [9:0] nxt_per_cnt;
	logic       armed_ff;
	logic       nxt_armed;
	logic       det_ff;
	logic       nxt_det;
	logic       rise;
	lnbt_pkg::lnbt_mode_t mode;
	logic [9:0] per_min;
	logic [9:0] per_max;
	logic       amp_ok;

	// accept band test shared by the detector and its checks
	function automatic logic in_band(input logic [9:0] per, input logic [9:0] lo,
		input logic [9:0] hi);
		return (per >= lo) && (per <= hi);
	endfunction : in_band

	// mode follows the tone gate directly
	always_comb begin
		mode    = tone_enable_input ? lnbt_pkg::MODE_XMT : lnbt_pkg::MODE_RCV;
		per_min = lnbt_pkg::RCV_PER_MIN;
		per_max = lnbt_pkg::RCV_PER_MAX;
		amp_ok  = sense.amp_rcv_ok;
		case (mode)
			lnbt_pkg::MODE_XMT: begin
				per_min = lnbt_pkg::XMT_PER_MIN;
				per_max = lnbt_pkg::XMT_PER_MAX;
				amp_ok  = sense.amp_xmt_ok;
			end
			lnbt_pkg::MODE_RCV: begin
				per_min = lnbt_pkg::RCV_PER_MIN;
				per_max = lnbt_pkg::RCV_PER_MAX;
				amp_ok  = sense.amp_rcv_ok;
			end
			default: begin
				per_min = lnbt_pkg::RCV_PER_MIN;
				per_max = lnbt_pkg::RCV_PER_MAX;
				amp_ok  = sense.amp_rcv_ok;
			end
		endcase
	end

	// one good period after the first edge is enough, keeping delay near 1.5 periods
	always_comb begin
		rise        = sense.tone_sense & ~sense_d_ff;
		nxt_per_cnt = per_cnt_ff;
		nxt_armed   = armed_ff;
		nxt_det     = det_ff;
		if (rise) begin
			nxt_per_cnt = 10'h001;
			nxt_armed   = 1'b1;
			nxt_det     = armed_ff && amp_ok &&
				in_band(per_cnt_ff, per_min, per_max);
		end else if (per_cnt_ff > lnbt_pkg::RCV_PER_MAX) begin
			nxt_armed = 1'b0; // tone gone, no edge within the widest band
			nxt_det   = 1'b0;
		end else begin
			nxt_per_cnt = per_cnt_ff + 10'h001;
		end
	end

	// detector state; idle sense is low, so no false edge after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_d_ff <= 1'b0;
			per_cnt_ff <= 10'h000;
			armed_ff   <= 1'b0;
			det_ff     <= 1'b0;
		end else begin
			sense_d_ff <= sense.tone_sense;
			per_cnt_ff <= nxt_per_cnt;
			armed_ff   <= nxt_armed;
			det_ff     <= nxt_det;
		end
	end

	// registered outputs
	logic lnb_on_ff;
	logic nxt_lnb_on;
	logic boost_gate_ff;
	logic nxt_boost_gate;
	logic tone_out_ff;
	logic nxt_tone_out;
	logic pulldown_ff;
	logic xmt_ff;
	logic flag_ff;
	logic tdo_oe_ff;

	// back-drive only masks the output, so it recovers by itself
	always_comb begin
		nxt_lnb_on     = output_enable & ~fault_ff & ~nxt_fault & ~sense.backdrive;
		nxt_boost_gate = boost_ph & ~skip_ff & output_enable & ~fault_ff;
		nxt_tone_out   = tone_ph & tone_enable_input;
	end

	// output flops, so every port is glitch free
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lnb_on_ff     <= 1'b0;
			boost_gate_ff <= 1'b0;
			tone_out_ff   <= 1'b0;
			pulldown_ff   <= 1'b0;
			xmt_ff        <= 1'b0;
			flag_ff       <= 1'b0;
			tdo_oe_ff     <= 1'b0;
		end else begin
			lnb_on_ff     <= nxt_lnb_on;
			boost_gate_ff <= nxt_boost_gate;
			tone_out_ff   <= nxt_tone_out;
			pulldown_ff   <= tone_enable_input;
			xmt_ff        <= tone_enable_input;
			flag_ff       <= det_ff;
			tdo_oe_ff     <= det_ff; // pulls low while tone present
		end
	end

	// ports straight from the flops, except tdo_out tied low
	assign lnb_output_on          = lnb_on_ff;
	assign overcurrent_fault_flag = fault_ff;
	assign boost_gate             = boost_gate_ff;
	assign tone_out               = tone_out_ff;
	assign pulldown_strong        = pulldown_ff;
	assign detect_mode_xmt        = xmt_ff;
	assign tone_detected_flag     = flag_ff;
	assign tdo_out                = 1'b0; // open drain: only ever drives low
	assign tdo_oe                 = tdo_oe_ff;

	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	fault_set_a: assert property (oc_expire |=> fault_ff)
		else $error("fault not latched at window expiry");
	fault_hold_a: assert property (fault_ff && !reenable_pulse |=> fault_ff)
		else $error("fault cleared without re-enable");
	out_off_a: assert property (fault_ff |=> !lnb_on_ff)
		else $error("output on while faulted");
	window_clr_a: assert property (!sense.oc_over_limit |=> oc_cnt_ff == '0)
		else $error("window not restarted");
	tone_gate_a: assert property (!tone_enable_input |=> !tone_out_ff)
		else $error("tone out while disabled");
	pulldown_on_a: assert property (tone_enable_input |=> pulldown_ff)
		else $error("strong pull-down not selected");
	pulldown_off_a: assert property (!tone_enable_input |=> !pulldown_ff)
		else $error("strong pull-down left on");
	skip_hyst_a: assert property (skip_ff && !sense.boost_below_lo |=> skip_ff)
		else $error("skip released early");
	skip_gate_a: assert property (skip_ff |=> !boost_gate_ff)
		else $error("boost pulse while skipping");
	tdo_flag_a: assert property (tdo_oe_ff == flag_ff)
		else $error("detect pin and flag disagree");
	backdrive_a: assert property (sense.backdrive |=> !lnb_on_ff)
		else $error("output on under back-drive");

	// window counting, fault release and output recovery
	window_count_a: assert property (sense.oc_over_limit && output_enable && !fault_ff
		&& !oc_expire |=> oc_cnt_ff == $past(oc_cnt_ff) + OC_W'(1))
		else $error("overload edge not counted");
	early_fault_a: assert property (!fault_ff && !oc_expire |=> !fault_ff)
		else $error("fault latched before the window ran out");
	reen_clear_a: assert property (reenable_pulse && !oc_expire |=> !fault_ff)
		else $error("re-enable did not clear the fault");
	fault_boost_a: assert property (fault_ff |=> !boost_gate_ff)
		else $error("boost switching while faulted");
	recover_a: assert property ($fell(sense.backdrive) && output_enable && !fault_ff
		&& !oc_expire |=> lnb_on_ff) else $error("output did not recover after back-drive");
	skip_set_a: assert property (sense.boost_above_hi |=> skip_ff)
		else $error("skip not entered above the upper threshold");

	// tone and detector mode follow the gate one cycle later
	tone_follow_a: assert property (tone_enable_input |=> tone_out_ff == $past(tone_ph))
		else $error("tone out does not follow the tone phase");
	xmt_mode_a: assert property (tone_enable_input |=> xmt_ff)
		else $error("detector not in transmit mode");
	rcv_mode_a: assert property (!tone_enable_input |=> !xmt_ff)
		else $error("detector not in receive mode");

	// detector decisions at each rising edge of the sliced sense input, and its clear when edges stop
	band_reject_a: assert property (rise && !in_band(per_cnt_ff, per_min, per_max)
		|=> !det_ff) else $error("out-of-band period accepted");
	amp_reject_a: assert property (rise && !amp_ok |=> !det_ff)
		else $error("low amplitude tone accepted");
	detect_set_a: assert property (rise && armed_ff && amp_ok
		&& in_band(per_cnt_ff, per_min, per_max) |=> det_ff ##1 flag_ff && tdo_oe_ff)
		else $error("good tone period not reported");
	tone_gone_a: assert property (!rise && per_cnt_ff > lnbt_pkg::RCV_PER_MAX
		|=> !det_ff) else $error("flag held with no tone on the line");

	// main scenarios; the host waits a good while before re-enabling
	fault_cov_c: cover property (oc_expire ##[1:400] reenable_pulse);
	detect_cov_c: cover property ($rose(flag_ff) && xmt_ff);
	rcv_cov_c: cover property ($rose(flag_ff) && !xmt_ff);
	skip_cov_c: cover property ($rose(skip_ff) ##[1:200] $fell(skip_ff));
	restart_cov_c: cover property ($fell(fault_ff) ##[1:4] $rose(lnb_on_ff));
endmodule : lnbt_ctrl

/* verif/lnbt_lnb_model.sv */
// lnb converter model: far-side tone source and coax load
`timescale 1ns/10ps
module lnbt_lnb_model (
	input  wire logic       clk,        // clock
	input  wire logic       rst_n,      // reset, active low
	input  wire logic       send,       // converter sends tone
	input  wire logic [9:0] half_per,   // tone half period
	input  wire logic       amp_x,      // fits xmt window
	input  wire logic       amp_r,      // fits rcv window
	input  wire logic       short_load, // coax shorted
	input  wire logic       out_on,     // supply on coax
	output logic            tone_sense, // sliced tone
	output logic            amp_xmt_ok, // xmt comparator
	output logic            amp_rcv_ok, // rcv comparator
	output logic            over_limit  // load over limit
);
	logic [9:0] cnt_ff;
	// square wave; idle sense stays low since the input is ac coupled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n || !send) begin
			cnt_ff     <= 10'h000;
			tone_sense <= 1'b0;
		end else if (cnt_ff == 10'h000) begin
			cnt_ff     <= half_per - 10'h001;
			tone_sense <= ~tone_sense;
		end else begin
			cnt_ff <= cnt_ff - 10'h001;
		end
	end
	// comparators see signal only while a tone is on the line
	assign amp_xmt_ok = send & amp_x;
	assign amp_rcv_ok = send & amp_r;
	// a short only overloads while the supply is on
	assign over_limit = short_load & out_on;
endmodule : lnbt_lnb_model

/* verif/lnbt_ctrl_tb.sv */
// testbench for the overcurrent timer, boost gating and tone control block
`timescale 1ns/10ps
module lnbt_ctrl_tb;
	localparam int OC      = 50;
	localparam int TONE_P  = lnbt_pkg::BOOST_HALF_CYC * 2 * 16;
	localparam int DET_LIM = 684; // one and a half periods of a 456-cycle tone
	// mode, half period, xmt amp, rcv amp, expected flag
	localparam logic [13:0] ROWS [5] = '{{1'b1, 10'h0e4, 3'b111}, {1'b1, 10'h0e4, 3'b010},
		{1'b1, 10'h10e, 3'b110}, {1'b0, 10'h10e, 3'b111}, {1'b0, 10'h10e, 3'b100}};
	logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, reen = 1'b0, ton = 1'b0, hi = 1'b0;
	logic lo = 1'b0, bd = 1'b0, send = 1'b0, ax = 1'b0, ar = 1'b0, shrt = 1'b0;
	logic [9:0]            hp = 10'h0e4;
	logic                  on, flt, bg, tout, pds, mx, fl, tdo, oe, ts, axo, aro, ovr;
	lnbt_pkg::lnbt_sense_t sense;
	int                    bad_count = 0, checks = 0, n, k;

	always #50 clk = ~clk;
	assign sense = '{ovr, hi, lo, bd, ts, axo, aro};
	lnbt_ctrl #(.OC_CYC(OC), .OC_W(20)) DUT (.clk(clk), .rst_n(rst_n), .output_enable(en),
		.reenable_pulse(reen), .tone_enable_input(ton), .sense(sense), .lnb_output_on(on),
		.overcurrent_fault_flag(flt), .boost_gate(bg), .tone_out(tout),
		.pulldown_strong(pds), .detect_mode_xmt(mx), .tone_detected_flag(fl),
		.tdo_out(tdo), .tdo_oe(oe));
	lnbt_lnb_model lnb (.clk(clk), .rst_n(rst_n), .send(send), .half_per(hp), .amp_x(ax),
		.amp_r(ar), .short_load(shrt), .out_on(on), .tone_sense(ts), .amp_xmt_ok(axo),
		.amp_rcv_ok(aro), .over_limit(ovr));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	function automatic logic pick(input int w);
		case (w)
			0: return flt;
			1: return fl;
			2: return on;
			3: return bg;
			default: return tout;
		endcase
	endfunction : pick
	// bounded wait on one output, sampled mid-cycle; timeout ends the run
	task automatic wait_out(input int w, input logic v, input int lim, output int c);
		for (c = 0; c < lim; c++) begin
			@(negedge clk);
			if (pick(w) === v)
				return;
		end
		chk(32'h0, 32'h1);
		close_out();
	endtask : wait_out
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask : cyc
	task automatic nb(input int c);
		repeat (c) @(negedge clk);
	endtask : nb
	// cycles between two rising edges of one output
	task automatic period(input int w, output int p);
		int a;
		wait_out(w, 1'b0, 600, a);
		wait_out(w, 1'b1, 600, a);
		wait_out(w, 1'b0, 600, a);
		wait_out(w, 1'b1, 600, p);
		p = p + a + 2;
	endtask : period
	// count cycles in which an output is high
	task automatic highs(input int w, input int c);
		k = 0;
		repeat (c) begin
			@(negedge clk);
			k += int'(pick(w) === 1'b1);
		end
	endtask : highs

	initial begin
		cyc(4);
		chk(32'({on, flt, bg, tout, pds, mx, fl, oe, tdo}), 32'h0);
		rst_n <= 1'b1;
		cyc(1);
		en <= 1'b1;
		// one overload shorter than the window, one clear cycle, then an overload held until the fault latches
		cyc(1);
		shrt <= 1'b1;
		cyc(OC - 10);
		shrt <= 1'b0;
		cyc(1);
		shrt <= 1'b1;
		cyc(OC - 10);
		nb(1);
		chk(32'({flt, on}), 32'h1);
		wait_out(0, 1'b1, OC + 10, n);
		// the wait began with OC-10 overload edges counted, plus one edge before its first look
		chk(32'(n + OC - 10 + 1), 32'(OC));
		chk(32'(on), 32'h0);
		nb(20);
		chk(32'({flt, on}), 32'h2);
		// real gap is a second or more, scaled down to keep the run short
		cyc(1);
		shrt <= 1'b0;
		cyc(200);
		reen <= 1'b1;
		cyc(1);
		reen <= 1'b0;
		wait_out(2, 1'b1, 4, n);
		chk(32'(flt), 32'h0);
		// back-drive suspends the output without latching a fault
		cyc(1);
		bd <= 1'b1;
		nb(2);
		chk(32'({on, flt}), 32'h0);
		cyc(1);
		bd <= 1'b0;
		nb(2);
		chk(32'({on, flt}), 32'h2);
		period(3, n);
		chk(32'(n), 32'(lnbt_pkg::BOOST_HALF_CYC * 2));
		cyc(1);
		hi <= 1'b1;
		cyc(1);
		hi <= 1'b0;
		nb(2);
		highs(3, 100);
		chk(32'(k), 32'h0);
		cyc(1);
		lo <= 1'b1;
		cyc(1);
		lo <= 1'b0;
		wait_out(3, 1'b1, 40, n);
		cyc(1);
		ton <= 1'b1;
		nb(2);
		chk(32'({pds, mx}), 32'h3);
		period(4, n);
		chk(32'(n), 32'(TONE_P));
		cyc(1);
		ton <= 1'b0;
		nb(2);
		chk(32'({pds, mx}), 32'h0);
		highs(4, 500);
		chk(32'(k), 32'h0);
		// mode, band and amplitude table for the detector
		for (int i = 0; i < 5; i++) begin
			cyc(1);
			{ton, hp, ax, ar} <= ROWS[i][13:1];
			send <= 1'b1;
			nb(1300);
			chk(32'({fl, oe, tdo}), 32'({ROWS[i][0], ROWS[i][0], 1'b0}));
		end
		cyc(1);
		send <= 1'b0;
		nb(800);
		chk(32'({fl, oe}), 32'h0);
		cyc(1);
		{ton, hp, ax, ar} <= {1'b1, 10'h0e4, 2'b11};
		send <= 1'b1;
		wait_out(1, 1'b1, DET_LIM, n);
		chk(32'(oe), 32'h1);
		close_out();
	end
endmodule : lnbt_ctrl_tb
